// [coag_pkg.sv]
// Package for the operand address generator: modes, classes, opcode fields.
// Assumes an 8-bit CPU with 16-bit addresses and a byte-wide fetch stream.
package coag_pkg;
    typedef enum logic [2:0] {
        COAG_INH = 3'b000,
        COAG_IMM = 3'b001,
        COAG_DIR = 3'b010,
        COAG_EXT = 3'b011,
        COAG_IX = 3'b100,
        COAG_IX1 = 3'b101,
        COAG_IX2 = 3'b110,
        COAG_REL = 3'b111
    } coag_mode_t;

    typedef enum logic [1:0] {
        COAG_CLS_CTRL = 2'b00,
        COAG_CLS_REGMEM = 2'b01,
        COAG_CLS_RMW = 2'b10,
        COAG_CLS_BRANCH = 2'b11
    } coag_class_t;

    // Opcode high nibble groups
    localparam logic [3:0] COAG_HI_BITBR = 4'h0;
    localparam logic [3:0] COAG_HI_BITMAN = 4'h1;
    localparam logic [3:0] COAG_HI_REL = 4'h2;
    localparam logic [3:0] COAG_HI_RMW_DIR = 4'h3;
    localparam logic [3:0] COAG_HI_RMW_A = 4'h4;
    localparam logic [3:0] COAG_HI_RMW_X = 4'h5;
    localparam logic [3:0] COAG_HI_RMW_IX1 = 4'h6;
    localparam logic [3:0] COAG_HI_RMW_IX = 4'h7;
    localparam logic [3:0] COAG_HI_CTRL_A = 4'h8;
    localparam logic [3:0] COAG_HI_CTRL_B = 4'h9;
    localparam logic [3:0] COAG_HI_IMM = 4'ha;
    localparam logic [3:0] COAG_HI_DIR = 4'hb;
    localparam logic [3:0] COAG_HI_EXT = 4'hc;
    localparam logic [3:0] COAG_HI_IX2 = 4'hd;
    localparam logic [3:0] COAG_HI_IX1 = 4'he;
    localparam logic [3:0] COAG_HI_IX = 4'hf;
    // Low nibble of the read-modify-write test operation
    localparam logic [3:0] COAG_LO_TEST = 4'hd;
    // Low nibble of the multiply opcode in the control group
    localparam logic [3:0] COAG_LO_MUL = 4'h2;
    // Low nibble of store opcodes: 7 accumulator, f index
    localparam logic [2:0] COAG_LO_STORE = 3'h7;
    localparam logic [7:0] COAG_PAGE0_HI = 8'h00;
    localparam logic [15:0] COAG_PC_RESET = 16'h0000;
    localparam logic [15:0] COAG_ADDR_RESET = 16'h0000;
    localparam logic [1:0] COAG_LEN_RESET = 2'h1;
endpackage : coag_pkg

// [coag_len_decode.sv]
// Opcode classifier: mode, length, instruction class, write-back need.
// Assumes the opcode byte is stable for the cycle it is presented.
`timescale 1ns/1ps
`default_nettype none
module coag_len_decode (
    // Opcode
    input wire logic [7:0] opcode,
    // Decode results
    output coag_pkg::coag_mode_t mode,
    output coag_pkg::coag_class_t iclass,
    output logic [1:0] length,
    output logic write_back,
    output logic reads_mem
);
    import coag_pkg::*;
    logic [3:0] hi;
    logic [3:0] lo;
    assign hi = opcode[7:4];
    assign lo = opcode[3:0];

    always_comb begin
        mode = COAG_INH;
        iclass = COAG_CLS_CTRL;
        write_back = 1'b0;
        reads_mem = 1'b0;
        unique case (hi)
            COAG_HI_BITBR: begin
                // Bit test and branch: direct operand plus displacement
                mode = COAG_DIR; // RQ4
                iclass = COAG_CLS_BRANCH;
                reads_mem = 1'b1;
            end
            COAG_HI_BITMAN: begin
                mode = COAG_DIR; // RQ3
                iclass = COAG_CLS_RMW; // RQ15
                write_back = 1'b1;
                reads_mem = 1'b1;
            end
            COAG_HI_REL: begin
                mode = COAG_REL; // RQ9
                iclass = COAG_CLS_BRANCH;
            end
            COAG_HI_RMW_DIR, COAG_HI_RMW_IX1, COAG_HI_RMW_IX: begin
                mode = (hi == COAG_HI_RMW_DIR) ? COAG_DIR :
                       (hi == COAG_HI_RMW_IX1) ? COAG_IX1 : COAG_IX;
                iclass = COAG_CLS_RMW; // RQ13
                write_back = (lo != COAG_LO_TEST); // RQ14
                reads_mem = 1'b1;
            end
            COAG_HI_RMW_A, COAG_HI_RMW_X: begin
                mode = COAG_INH; // RQ1
                iclass = COAG_CLS_RMW;
                write_back = (lo != COAG_LO_TEST); // RQ14
            end
            COAG_HI_CTRL_A, COAG_HI_CTRL_B: begin
                mode = COAG_INH; // RQ1
                iclass = (hi == COAG_HI_CTRL_A && lo == COAG_LO_MUL) ?
                         COAG_CLS_REGMEM : COAG_CLS_CTRL;
            end
            COAG_HI_IMM, COAG_HI_DIR, COAG_HI_EXT,
            COAG_HI_IX2, COAG_HI_IX1, COAG_HI_IX: begin
                unique case (hi)
                    COAG_HI_IMM: mode = COAG_IMM; // RQ2
                    COAG_HI_DIR: mode = COAG_DIR;
                    COAG_HI_EXT: mode = COAG_EXT;
                    COAG_HI_IX2: mode = COAG_IX2;
                    COAG_HI_IX1: mode = COAG_IX1;
                    default: mode = COAG_IX;
                endcase
                iclass = COAG_CLS_REGMEM; // RQ12
                // Stores write memory and never read it
                reads_mem = (hi != COAG_HI_IMM) &&
                            (lo[2:0] != COAG_LO_STORE);
            end
        endcase
    end

    always_comb begin
        unique case (mode)
            COAG_INH, COAG_IX: length = 2'd1; // RQ1 RQ6
            COAG_IMM, COAG_IX1, COAG_REL: length = 2'd2; // RQ2 RQ7
            COAG_DIR: length = (hi == COAG_HI_BITBR) ? 2'd3 : 2'd2; // RQ4
            COAG_EXT, COAG_IX2: length = 2'd3; // RQ5 RQ8
        endcase
    end
endmodule : coag_len_decode
`default_nettype wire

// [coag_addr_gen.sv]
// Operation
// RQ1: No-operand forms are one byte and produce no memory address.
// RQ2: Immediate forms are two bytes; second byte is the literal operand.
// RQ3: Direct forms are two bytes; address high byte is zero.
// RQ4: Bit test and branch is three bytes: direct address, then displacement.
// RQ5: Extended forms are three bytes; high address byte then low.
// RQ6: Indexed without offset is one byte; address is zero page index.
// RQ7: Indexed 8-bit offset is two bytes; address is index plus byte.
// RQ8: Indexed 16-bit offset is three bytes; offset high first plus index.
// RQ9: Relative form is used only by branch instructions.
// RQ10: Taken branch goes to PC plus sign-extended displacement, else next.
// RQ11: Displacement is two's complement, -128..+127 from next instruction.
// RQ12: Register/memory ops pair accumulator or index with a memory operand.
// RQ13: Read-modify-write reads, transforms and writes back the same place.
// RQ14: The test operation reads and evaluates but never writes back.
// RQ15: Read-modify-write covers shifts, rotates, bit set/clear, clr, etc.
// RQ16: Carry beyond bit 15 in address or target sums is dropped.
//
// Instruction byte collector and effective address generator.
// Assumes fetch presents one instruction byte per ref_clk with byte_valid,
// and that the execute stage supplies index and branch condition.
`timescale 1ns/1ps
`default_nettype none
module coag_addr_gen (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Fetch stream
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic [15:0] byte_pc,
    // CPU state
    input wire logic [7:0] index_reg,
    input wire logic branch_cond,
    // Decoded instruction
    output logic instr_done,
    output coag_pkg::coag_mode_t instr_mode,
    output coag_pkg::coag_class_t instr_class,
    output logic [1:0] instr_len,
    output logic [7:0] instr_opcode,
    output logic [7:0] imm_data,
    output logic mem_valid,
    output logic [15:0] mem_addr,
    output logic mem_read,
    output logic mem_write_back,
    output logic [15:0] next_pc,
    output logic branch_taken
);
    import coag_pkg::*;

    typedef enum logic [1:0] {
        COAG_S_OPC = 2'b00,
        COAG_S_B2 = 2'b01,
        COAG_S_B3 = 2'b10
    } coag_state_t;

    coag_state_t state_r;
    logic [7:0] opc_r;
    logic [7:0] b2_r;
    logic [15:0] opc_pc_r;
    logic [7:0] cur_opc;
    coag_mode_t dec_mode;
    coag_class_t dec_class;
    logic [1:0] dec_len;
    logic dec_wb;
    logic dec_rd;
    logic last_byte;
    logic [7:0] b2_v;
    logic [7:0] disp_v;
    logic [15:0] pc_after;
    logic [15:0] ea_v;
    logic [16:0] sum_v;
    logic [15:0] target_v;
    logic take_last;

    // A lone opcode byte is decoded straight from the stream
    assign cur_opc = (state_r == COAG_S_OPC) ? byte_data : opc_r;

    coag_len_decode u_dec (
        .opcode(cur_opc),
        .mode(dec_mode),
        .iclass(dec_class),
        .length(dec_len),
        .write_back(dec_wb),
        .reads_mem(dec_rd)
    );

    always_comb begin
        unique case (state_r)
            COAG_S_OPC: last_byte = (dec_len == 2'd1);
            COAG_S_B2: last_byte = (dec_len == 2'd2);
            default: last_byte = 1'b1;
        endcase
    end

    // Second byte is live in B2 state, registered in B3 state
    assign b2_v = (state_r == COAG_S_B2) ? byte_data : b2_r;
    // Displacement is always the final byte of a branch
    assign disp_v = byte_data;
    assign pc_after = opc_pc_r + {14'h0000, dec_len}; // RQ11 RQ16

    always_comb begin
        sum_v = 17'h0_0000;
        unique case (dec_mode)
            COAG_DIR: ea_v = {COAG_PAGE0_HI, b2_v}; // RQ3 RQ4
            COAG_EXT: ea_v = {b2_v, byte_data}; // RQ5
            COAG_IX: ea_v = {COAG_PAGE0_HI, index_reg}; // RQ6
            COAG_IX1: begin
                // Carry kept: reaches up to 0x01fe
                sum_v = {9'h000, index_reg} + {9'h000, byte_data}; // RQ7
                ea_v = sum_v[15:0];
            end
            COAG_IX2: begin
                sum_v = {1'b0, b2_v, byte_data} +
                        {9'h000, index_reg}; // RQ8
                ea_v = sum_v[15:0]; // RQ16
            end
            default: ea_v = COAG_ADDR_RESET; // RQ1 RQ2
        endcase
    end

    // Sign extension, wrap within 16 bits
    assign target_v = pc_after + {{8{disp_v[7]}}, disp_v}; // RQ10 RQ11 RQ16

    // Completes on the edge that takes the final byte
    assign take_last = byte_valid && last_byte;

    // Gaps between bytes leave the collector where it is
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            state_r <= COAG_S_OPC;
        end else if (byte_valid) begin
            if (last_byte) begin
                state_r <= COAG_S_OPC;
            end else if (state_r == COAG_S_OPC) begin
                state_r <= COAG_S_B2;
            end else begin
                state_r <= COAG_S_B3;
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            opc_r <= 8'h00;
            opc_pc_r <= COAG_PC_RESET;
            b2_r <= 8'h00;
        end else if (byte_valid) begin
            if (state_r == COAG_S_OPC) begin
                opc_r <= byte_data;
                opc_pc_r <= byte_pc;
            end
            if (state_r == COAG_S_B2) begin
                b2_r <= byte_data;
            end
        end
    end

    // One-cycle pulse; every other output holds until the next one
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            instr_done <= 1'b0;
        end else begin
            instr_done <= take_last;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            instr_mode <= COAG_INH;
            instr_class <= COAG_CLS_CTRL;
            instr_len <= COAG_LEN_RESET;
            instr_opcode <= 8'h00;
            imm_data <= 8'h00;
        end else if (take_last) begin
            instr_mode <= dec_mode;
            instr_class <= dec_class;
            instr_len <= dec_len;
            instr_opcode <= cur_opc;
            // Literal operand, no address
            imm_data <= (dec_mode == COAG_IMM) ? byte_data : 8'h00; // RQ2
        end
    end

    // Address reads zero when no operand lives in memory
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            mem_valid <= 1'b0;
            mem_addr <= COAG_ADDR_RESET;
            mem_read <= 1'b0;
            mem_write_back <= 1'b0;
        end else if (take_last) begin
            mem_valid <= (dec_mode != COAG_INH) &&
                         (dec_mode != COAG_IMM) &&
                         (dec_mode != COAG_REL); // RQ1 RQ9
            mem_addr <= ea_v;
            mem_read <= dec_rd; // RQ12
            mem_write_back <= dec_wb; // RQ13 RQ14
        end
    end

    // Branch condition counts only with the final byte
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            next_pc <= COAG_PC_RESET;
            branch_taken <= 1'b0;
        end else if (take_last) begin
            if (state_r == COAG_S_OPC) begin
                next_pc <= byte_pc + 16'h0001;
                branch_taken <= 1'b0;
            end else if (dec_class == COAG_CLS_BRANCH && branch_cond) begin
                next_pc <= target_v; // RQ10
                branch_taken <= 1'b1;
            end else begin
                next_pc <= pc_after; // RQ10
                branch_taken <= 1'b0;
            end
        end
    end
endmodule : coag_addr_gen
`default_nettype wire

// [coag_addr_gen_asserts.sv]
// Checker for the operand address generator, bound to its top module.
// Assumes index and branch condition are stable in the last byte's cycle.
`timescale 1ns/1ps
`default_nettype none
module coag_addr_gen_asserts
    import coag_pkg::*;
(
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst_b,
    // Fetch and CPU state
    input wire logic byte_valid,
    input wire logic [7:0] byte_data,
    input wire logic [7:0] index_reg,
    input wire logic branch_cond,
    // Decoded instruction
    input wire logic instr_done,
    input wire coag_pkg::coag_mode_t instr_mode,
    input wire coag_pkg::coag_class_t instr_class,
    input wire logic [1:0] instr_len,
    input wire logic [7:0] instr_opcode,
    input wire logic [7:0] imm_data,
    input wire logic mem_valid,
    input wire logic [15:0] mem_addr,
    input wire logic mem_write_back,
    input wire logic branch_taken
);
    import coag_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    chk_done_after_byte: assert property (instr_done |-> $past(byte_valid))
        else $error("done without a byte taken");
    chk_inh_no_addr: assert property (
        instr_done && instr_mode == COAG_INH |-> !mem_valid && instr_len == 1)
        else $error("inherent form wrong");
    chk_imm_literal: assert property (instr_done && instr_mode == COAG_IMM
        |-> instr_len == 2 && !mem_valid && imm_data == $past(byte_data))
        else $error("immediate form wrong");
    chk_dir_page: assert property (instr_done && instr_mode == COAG_DIR
        && instr_opcode[7:4] != 4'h0 |-> mem_addr[15:8] == 8'h00)
        else $error("direct high byte not zero");
    chk_bitbr_len: assert property (
        instr_done && instr_opcode[7:4] == 4'h0 |-> instr_len == 3)
        else $error("bit branch length wrong");
    chk_ext_low: assert property (instr_done && instr_mode == COAG_EXT
        |-> instr_len == 3 && mem_addr[7:0] == $past(byte_data))
        else $error("extended address wrong");
    chk_ix_addr: assert property (instr_done && instr_mode == COAG_IX
        |-> mem_addr == {8'h00, $past(index_reg)})
        else $error("indexed address wrong");
    chk_ix1_sum: assert property (instr_done && instr_mode == COAG_IX1
        |-> mem_addr == 16'($past(index_reg)) + 16'($past(byte_data)))
        else $error("indexed offset sum wrong");
    chk_ix2_len: assert property (
        instr_done && instr_mode == COAG_IX2 |-> instr_len == 3)
        else $error("16-bit offset length wrong");
    chk_rel_branch: assert property (
        instr_done && instr_mode == COAG_REL |-> instr_class == COAG_CLS_BRANCH)
        else $error("relative form outside branch class");
    chk_taken_cond: assert property (instr_done |->
        branch_taken == (instr_class == COAG_CLS_BRANCH && $past(branch_cond)))
        else $error("branch taken flag wrong");
    chk_test_no_wb: assert property (instr_done &&
        instr_class == COAG_CLS_RMW && instr_opcode[7:4] != COAG_HI_BITMAN
        && instr_opcode[3:0] == COAG_LO_TEST |-> !mem_write_back)
        else $error("test operation writes back");
endmodule : coag_addr_gen_asserts
bind coag_addr_gen coag_addr_gen_asserts u_chk (.ref_clk, .rst_b,
    .byte_valid, .byte_data, .index_reg, .branch_cond, .instr_done,
    .instr_mode, .instr_class, .instr_len, .instr_opcode, .imm_data,
    .mem_valid, .mem_addr, .mem_write_back, .branch_taken);
`default_nettype wire

// [coag_fetch_model.sv]
// Fetch stream model: presents instruction bytes at the falling edge.
// Assumes the caller waits for each instruction to complete.
`timescale 1ns/1ps
`default_nettype none
module coag_fetch_model (
    // Clock
    input wire logic ref_clk,
    // Fetch stream
    output var logic byte_valid,
    output var logic [7:0] byte_data,
    output var logic [15:0] byte_pc
);
    initial begin
        byte_valid = 1'b0;
        byte_data = 8'h00;
        byte_pc = 16'h0000;
    end
    // Idle lines flip so stale bytes never look valid
    task idle;
        byte_valid = 1'b0;
        byte_data = ~byte_data;
        byte_pc = ~byte_pc;
    endtask : idle
    task automatic send(input logic [7:0] op, b1, b2, input int n,
            input logic [15:0] pc, input logic gap);
        logic [7:0] q[3];
        q = '{op, b1, b2};
        for (int i = 0; i < n; i++) begin
            if (gap && i == 1) begin
                @(negedge ref_clk);
                idle();
            end
            @(negedge ref_clk);
            byte_valid = 1'b1;
            byte_data = q[i];
            byte_pc = pc + 16'(i);
        end
        @(negedge ref_clk);
        idle();
    endtask : send
endmodule : coag_fetch_model
`default_nettype wire

// [cpu_operand_address_generator_test.sv]
// Self-checking bench: random instructions against an integer model.
// Assumes the fetch model and checker files are compiled first.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin n_mismatch++; \
    $display("mismatch %s exp %h got %h", n, e, g); end end
module cpu_operand_address_generator_test;
    import coag_pkg::*;
    logic ref_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] index_reg = 8'h00;
    logic branch_cond = 1'b0;
    logic byte_valid, instr_done, mem_valid, mem_read, mem_write_back, tk;
    logic [7:0] byte_data, instr_opcode, imm_data, op, b1, b2, last;
    logic [15:0] byte_pc, mem_addr, next_pc, s, pc, ea;
    logic [1:0] instr_len;
    logic branch_taken;
    coag_mode_t instr_mode;
    coag_class_t instr_class;
    int checks = 0;
    int n_mismatch = 0;
    int lens[16] = '{3, 2, 2, 2, 1, 1, 2, 1, 1, 1, 2, 2, 3, 3, 2, 1};
    coag_mode_t modes[16] = '{COAG_DIR, COAG_DIR, COAG_REL, COAG_DIR,
        COAG_INH, COAG_INH, COAG_IX1, COAG_IX, COAG_INH, COAG_INH, COAG_IMM,
        COAG_DIR, COAG_EXT, COAG_IX2, COAG_IX1, COAG_IX};
    coag_class_t cls;
    logic ev;
    logic [15:0] npc;
    int n, k;
    always #2 ref_clk = ~ref_clk;
    coag_fetch_model u_fetch (.ref_clk, .byte_valid, .byte_data, .byte_pc);
    coag_addr_gen DUT (.ref_clk, .rst_b, .byte_valid, .byte_data, .byte_pc,
        .index_reg, .branch_cond, .instr_done, .instr_mode, .instr_class,
        .instr_len, .instr_opcode, .imm_data, .mem_valid, .mem_addr,
        .mem_read, .mem_write_back, .next_pc, .branch_taken);
    function automatic logic [15:0] lfsr(input logic [15:0] v);
        return v[0] ? (v >> 1) ^ 16'hb400 : v >> 1;
    endfunction : lfsr
    task results;
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : results
    initial begin
        s = 16'h6e95;
        repeat (8) @(negedge ref_clk);
        rst_b = 1'b1;
        for (int i = 0; i < 300; i++) begin
            s = lfsr(s);
            op = s[7:0];
            b1 = s[15:8];
            s = lfsr(s);
            b2 = s[7:0];
            index_reg = s[15:8];
            s = lfsr(s);
            // Every fourth start near the top to force 16-bit wrap
            pc = (i % 4 == 0) ? 16'hfffe : s;
            branch_cond = s[3];
            n = lens[op[7:4]];
            last = (n == 3) ? b2 : b1;
            case (op[7:4])
                4'h0, 4'h1, 4'h3, 4'hb: ea = {8'h00, b1};
                4'h6, 4'he: ea = {8'h00, b1} + {8'h00, index_reg};
                4'h7, 4'hf: ea = {8'h00, index_reg};
                4'hc: ea = {b1, b2};
                4'hd: ea = {b1, b2} + {8'h00, index_reg};
                default: ea = 16'h0000;
            endcase
            tk = (op[7:4] == 4'h0 || op[7:4] == 4'h2) && branch_cond;
            case (op[7:4])
                4'h0, 4'h2: cls = COAG_CLS_BRANCH;
                4'h1, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7: cls = COAG_CLS_RMW;
                4'h8: cls = (op[3:0] == COAG_LO_MUL) ? COAG_CLS_REGMEM :
                    COAG_CLS_CTRL;
                4'h9: cls = COAG_CLS_CTRL;
                default: cls = COAG_CLS_REGMEM;
            endcase
            u_fetch.send(op, b1, b2, n, pc, s[9]);
            k = 0;
            while (instr_done !== 1'b1 && k < 4) begin
                @(negedge ref_clk);
                k++;
            end
            if (instr_done !== 1'b1) begin
                n_mismatch++;
                $display("mismatch instr_done exp 1 got %b", instr_done);
                results();
            end
            `CHK("instr_len", 2'(n), instr_len)
            `CHK("mem_addr", ea, mem_addr)
            ev = !(op[7:4] inside {2, 4, 5, 8, 9, 10});
            `CHK("mem_valid", ev, mem_valid)
            `CHK("imm_data", (op[7:4] == 4'ha) ? b1 : 8'h00, imm_data)
            `CHK("branch_taken", tk, branch_taken)
            npc = pc + 16'(n) + (tk ? {{8{last[7]}}, last} : 16'h0000);
            `CHK("next_pc", npc, next_pc)
            ev = op[7:4] == 4'h1 ||
                (op[7:4] inside {[3:7]} && op[3:0] != COAG_LO_TEST);
            `CHK("mem_write_back", ev, mem_write_back)
            ev = op[7:4] inside {0, 1, 3, 6, 7} ||
                (op[7:4] > 4'ha && op[2:0] != COAG_LO_STORE);
            `CHK("mem_read", ev, mem_read)
            `CHK("instr_opcode", op, instr_opcode)
            `CHK("instr_mode", modes[op[7:4]], instr_mode)
            `CHK("instr_class", cls, instr_class)
        end
        results();
    end
endmodule : cpu_operand_address_generator_test
`default_nettype wire
